/* verilog/ilcd_consts.svh */
`ifndef ILCD_CONSTS_SVH
`define ILCD_CONSTS_SVH
`define ILCD_CLK_PERIOD_NS 4
`define ILCD_LEN_RESET 2'h0
`define ILCD_CYC_RESET 2'h0
`define ILCD_OP_XRL_DIR_IMM 8'h63
`define ILCD_OP_CLR_A 8'hE4
`define ILCD_OP_CPL_A 8'hF4
`define ILCD_OP_RL_A 8'h23
`define ILCD_OP_RLC_A 8'h33
`define ILCD_OP_RR_A 8'h03
`define ILCD_OP_RRC_A 8'h13
`define ILCD_OP_SWAP_A 8'hC4
`define ILCD_OP_A_DIR 8'hE5
`define ILCD_OP_A_IMM 8'h74
`define ILCD_OP_DIR_A 8'hF5
`define ILCD_OP_DIR_DIR 8'h85
`define ILCD_OP_DIR_IMM 8'h75
`define ILCD_OP_IND_DIR 8'hA6
`define ILCD_OP_IND_IMM 8'h76
`define ILCD_OP_DATA_POINTER_IMM 8'h90
`define ILCD_OP_CODE_DATA_POINTER 8'h93
`define ILCD_OP_CODE_PC 8'h83
`define ILCD_OP_XRD_DATA_POINTER 8'hE0
`define ILCD_OP_XWR_DATA_POINTER 8'hF0
`define ILCD_OP_PUSH 8'hC0
`define ILCD_OP_POP 8'hD0
`define ILCD_OP_XCH_DIR 8'hC5
`define ILCD_OP_CLR_C 8'hC3
`define ILCD_OP_CLR_BIT 8'hC2
`define ILCD_OP_SET_C 8'hD3
`define ILCD_OP_SET_BIT 8'hD2
`define ILCD_OP_CPL_C 8'hB3
`define ILCD_OP_CPL_BIT 8'hB2
`endif

/* verilog/ilcd_pkg.sv */
package ilcd_pkg;
	typedef enum logic [4:0] {
		ILCD_NONE, ILCD_ACC_LOGIC, ILCD_ACC_ROTATE, ILCD_MOVE_REG, ILCD_MOVE_DIRECT,
		ILCD_MOVE_INDIRECT, ILCD_MOVE_IMM, ILCD_MOVE_DATA_POINTER, ILCD_CODE_MOVE,
		ILCD_EXT_MOVE, ILCD_STACK, ILCD_EXCHANGE, ILCD_EXCH_NIBBLE, ILCD_BIT_OP,
		ILCD_CARRY_OP
	} ilcd_class_e;
	typedef struct packed {
		logic valid;
		logic [1:0] length;
		logic [1:0] cycles;
		ilcd_class_e op_class;
	} ilcd_dec_s;
endpackage : ilcd_pkg

/* verilog/ilcd_decoder.sv */
`include "ilcd_consts.svh"
module ilcd_decoder (
	input wire logic clk,
	input wire logic reset,
	input wire logic opcode_valid,
	input wire logic [7:0] opcode,
	output ilcd_pkg::ilcd_dec_s dec_out,
	output logic busy,
	output logic instr_done
);
	function automatic ilcd_pkg::ilcd_dec_s dec(input logic [7:0] op);
		ilcd_pkg::ilcd_dec_s d;
		d = '{1'b1, 2'h0, 2'h0, ilcd_pkg::ILCD_NONE};
		if (op == `ILCD_OP_XRL_DIR_IMM)
			d = '{1'b1, 2'h3, 2'h3, ilcd_pkg::ILCD_ACC_LOGIC};
		else if (op == `ILCD_OP_CLR_A || op == `ILCD_OP_CPL_A)
			d = '{1'b1, 2'h1, 2'h1, ilcd_pkg::ILCD_ACC_LOGIC};
		else if (op == `ILCD_OP_RL_A || op == `ILCD_OP_RLC_A || op == `ILCD_OP_RR_A
			|| op == `ILCD_OP_RRC_A || op == `ILCD_OP_SWAP_A)
			d = '{1'b1, 2'h1, 2'h1, ilcd_pkg::ILCD_ACC_ROTATE};
		else if (op[7:1] == 7'h73)
			d = '{1'b1, 2'h1, 2'h2, ilcd_pkg::ILCD_MOVE_INDIRECT};
		else if (op == `ILCD_OP_A_DIR || op == `ILCD_OP_A_IMM)
			d = '{1'b1, 2'h2, 2'h2, ilcd_pkg::ILCD_MOVE_DIRECT};
		else if (op[7:3] == 5'h0F)
			d = '{1'b1, 2'h2, 2'h2, ilcd_pkg::ILCD_MOVE_IMM};
		else if (op[7:3] == 5'h1D || op[7:3] == 5'h1F)
			d = '{1'b1, 2'h1, 2'h1, ilcd_pkg::ILCD_MOVE_REG};
		else if (op[7:3] == 5'h15)
			d = '{1'b1, 2'h2, 2'h2, ilcd_pkg::ILCD_MOVE_DIRECT};
		else if (op[7:3] == 5'h11 || op == `ILCD_OP_DIR_A)
			d = '{1'b1, 2'h2, 2'h2, ilcd_pkg::ILCD_MOVE_DIRECT};
		else if (op == `ILCD_OP_DIR_DIR)
			d = '{1'b1, 2'h3, 2'h3, ilcd_pkg::ILCD_MOVE_DIRECT};
		else if (op == `ILCD_OP_DIR_IMM)
			d = '{1'b1, 2'h3, 2'h3, ilcd_pkg::ILCD_MOVE_IMM};
		else if (op[7:1] == 7'h43)
			d = '{1'b1, 2'h2, 2'h2, ilcd_pkg::ILCD_MOVE_INDIRECT};
		else if (op[7:1] == 7'h7B)
			d = '{1'b1, 2'h1, 2'h2, ilcd_pkg::ILCD_MOVE_INDIRECT};
		else if (op[7:1] == 7'h53 || op[7:1] == 7'h3B)
			d = '{1'b1, 2'h2, 2'h2, ilcd_pkg::ILCD_MOVE_INDIRECT};
		else if (op == `ILCD_OP_DATA_POINTER_IMM)
			d = '{1'b1, 2'h3, 2'h3, ilcd_pkg::ILCD_MOVE_DATA_POINTER};
		else if (op == `ILCD_OP_CODE_DATA_POINTER || op == `ILCD_OP_CODE_PC)
			d = '{1'b1, 2'h1, 2'h3, ilcd_pkg::ILCD_CODE_MOVE};
		// low bits 01 in these rows are jumps and calls, not data moves
		else if ((op[7:2] == 6'h38 || op[7:2] == 6'h3C) && op[1:0] != 2'h1)
			d = '{1'b1, 2'h1, 2'h3, ilcd_pkg::ILCD_EXT_MOVE};
		else if (op == `ILCD_OP_PUSH || op == `ILCD_OP_POP)
			d = '{1'b1, 2'h2, 2'h2, ilcd_pkg::ILCD_STACK};
		else if (op == `ILCD_OP_XCH_DIR)
			d = '{1'b1, 2'h2, 2'h2, ilcd_pkg::ILCD_EXCHANGE};
		else if (op[7:3] == 5'h19)
			d = '{1'b1, 2'h1, 2'h1, ilcd_pkg::ILCD_EXCHANGE};
		else if (op[7:1] == 7'h63)
			d = '{1'b1, 2'h1, 2'h2, ilcd_pkg::ILCD_EXCHANGE};
		else if (op[7:1] == 7'h6B)
			d = '{1'b1, 2'h1, 2'h2, ilcd_pkg::ILCD_EXCH_NIBBLE};
		else if (op == `ILCD_OP_CLR_BIT || op == `ILCD_OP_SET_BIT || op == `ILCD_OP_CPL_BIT)
			d = '{1'b1, 2'h2, 2'h2, ilcd_pkg::ILCD_BIT_OP};
		else if (op == `ILCD_OP_CLR_C || op == `ILCD_OP_SET_C || op == `ILCD_OP_CPL_C)
			d = '{1'b1, 2'h1, 2'h1, ilcd_pkg::ILCD_CARRY_OP};
		else
			d.valid = 1'b0;
		return d;
	endfunction : dec

	logic [1:0] left_reg;
	ilcd_pkg::ilcd_dec_s cur;
	logic take;

	// opcodes offered while busy are ignored; fetch must wait
	assign take = opcode_valid && !busy;
	assign cur = dec(opcode);

	always_ff @(posedge clk)
	begin
		if (reset)
			dec_out <= '{1'b0, `ILCD_LEN_RESET, `ILCD_CYC_RESET, ilcd_pkg::ILCD_NONE};
		else if (take)
			dec_out <= cur;
	end

	// cycle 0 is the accepting edge; unknown opcodes take one cycle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			busy <= 1'b0;
			left_reg <= 2'h0;
			instr_done <= 1'b0;
		end
		else if (take)
		begin
			left_reg <= (cur.cycles > 2'h1) ? cur.cycles - 2'h2 : 2'h0;
			busy <= cur.cycles > 2'h1;
			instr_done <= cur.cycles <= 2'h1;
		end
		else if (busy)
		begin
			left_reg <= (left_reg == 2'h0) ? 2'h0 : left_reg - 2'h1;
			busy <= left_reg != 2'h0;
			instr_done <= left_reg == 2'h0;
		end
		else
			instr_done <= 1'b0;
	end

	// timing steps shared by the multi-cycle checks
	sequence ilcd_last_cycle;
		!busy && instr_done;
	endsequence

	sequence ilcd_busy_then_last;
		busy ##1 ilcd_last_cycle;
	endsequence

	sequence ilcd_busy_twice_then_last;
		busy ##1 ilcd_busy_then_last;
	endsequence

	// opcode pattern against the registered length and cycle fields
	property ilcd_shape(hit, len, cyc);
		@(posedge clk) disable iff (reset)
		take && hit |=> dec_out.valid && dec_out.length == len && dec_out.cycles == cyc;
	endproperty

	AST_LEN_MATCH: assert property (@(posedge clk) disable iff (reset)
		take |=> dec_out.cycles >= dec_out.length)
		else $error("cycle count below length");

	AST_THREE_CYC: assert property (@(posedge clk) disable iff (reset)
		take && cur.cycles == 2'h3 |=> ilcd_busy_twice_then_last)
		else $error("three cycle instruction timing wrong");

	AST_TWO_CYC: assert property (@(posedge clk) disable iff (reset)
		take && cur.cycles == 2'h2 |=> ilcd_busy_then_last)
		else $error("two cycle instruction timing wrong");

	AST_ONE_CYC: assert property (@(posedge clk) disable iff (reset)
		take && cur.cycles == 2'h1 |=> ilcd_last_cycle)
		else $error("one cycle instruction timing wrong");

	AST_XRL: assert property (
		ilcd_shape(opcode == `ILCD_OP_XRL_DIR_IMM, 2'h3, 2'h3))
		else $error("xor immediate decode wrong");

	AST_ACC_OPS: assert property (
		ilcd_shape(opcode == `ILCD_OP_CLR_A || opcode == `ILCD_OP_CPL_A
			|| opcode == `ILCD_OP_RL_A || opcode == `ILCD_OP_RLC_A || opcode == `ILCD_OP_RR_A
			|| opcode == `ILCD_OP_RRC_A || opcode == `ILCD_OP_SWAP_A, 2'h1, 2'h1))
		else $error("accumulator operation decode wrong");

	AST_IND_TO_ACC: assert property (
		ilcd_shape(opcode[7:1] == 7'h73, 2'h1, 2'h2))
		else $error("indirect to accumulator decode wrong");

	AST_TO_ACC: assert property (
		ilcd_shape(opcode == `ILCD_OP_A_DIR || opcode == `ILCD_OP_A_IMM, 2'h2, 2'h2))
		else $error("direct or immediate to accumulator decode wrong");

	AST_IMM_TO_REG: assert property (
		ilcd_shape(opcode[7:3] == 5'h0F, 2'h2, 2'h2))
		else $error("immediate to register decode wrong");

	AST_REG_ACC: assert property (
		ilcd_shape(opcode[7:3] == 5'h1D || opcode[7:3] == 5'h1F, 2'h1, 2'h1))
		else $error("register accumulator move decode wrong");

	AST_DIR_TO_REG: assert property (
		ilcd_shape(opcode[7:3] == 5'h15, 2'h2, 2'h2))
		else $error("direct to register decode wrong");

	AST_TO_DIR: assert property (
		ilcd_shape(opcode[7:3] == 5'h11 || opcode == `ILCD_OP_DIR_A, 2'h2, 2'h2))
		else $error("register or accumulator to direct decode wrong");

	AST_DIR_DIR: assert property (
		ilcd_shape(opcode == `ILCD_OP_DIR_DIR, 2'h3, 2'h3))
		else $error("direct to direct decode wrong");

	AST_IMM_DIR: assert property (
		ilcd_shape(opcode == `ILCD_OP_DIR_IMM, 2'h3, 2'h3))
		else $error("immediate to direct decode wrong");

	AST_IND_DIR: assert property (
		ilcd_shape(opcode[7:1] == 7'h43, 2'h2, 2'h2))
		else $error("indirect to direct decode wrong");

	AST_ACC_IND: assert property (
		ilcd_shape(opcode[7:1] == 7'h7B, 2'h1, 2'h2))
		else $error("accumulator to indirect decode wrong");

	AST_TO_IND: assert property (
		ilcd_shape(opcode[7:1] == 7'h53 || opcode[7:1] == 7'h3B, 2'h2, 2'h2))
		else $error("direct or immediate to indirect decode wrong");

	AST_DATA_POINTER: assert property (
		ilcd_shape(opcode == `ILCD_OP_DATA_POINTER_IMM, 2'h3, 2'h3))
		else $error("data pointer load decode wrong");

	AST_CODE: assert property (
		ilcd_shape(opcode == `ILCD_OP_CODE_DATA_POINTER || opcode == `ILCD_OP_CODE_PC, 2'h1, 2'h3))
		else $error("code byte move decode wrong");

	AST_EXT: assert property (
		ilcd_shape((opcode[7:2] == 6'h38 || opcode[7:2] == 6'h3C) && opcode[1:0] != 2'h1,
			2'h1, 2'h3))
		else $error("external move decode wrong");

	AST_NOT_EXT: assert property (@(posedge clk) disable iff (reset)
		take && (opcode == 8'hE1 || opcode == 8'hF1) |=> !dec_out.valid)
		else $error("jump row taken as external move");

	AST_STACK: assert property (
		ilcd_shape(opcode == `ILCD_OP_PUSH || opcode == `ILCD_OP_POP, 2'h2, 2'h2))
		else $error("stack decode wrong");

	AST_XCH_DIR: assert property (
		ilcd_shape(opcode == `ILCD_OP_XCH_DIR, 2'h2, 2'h2))
		else $error("direct exchange decode wrong");

	AST_XCH_REG: assert property (
		ilcd_shape(opcode[7:3] == 5'h19, 2'h1, 2'h1))
		else $error("register exchange decode wrong");

	AST_XCH_IND: assert property (
		ilcd_shape(opcode[7:1] == 7'h63 || opcode[7:1] == 7'h6B, 2'h1, 2'h2))
		else $error("indirect exchange decode wrong");

	AST_BIT_OPS: assert property (
		ilcd_shape(opcode == `ILCD_OP_CLR_BIT || opcode == `ILCD_OP_SET_BIT
			|| opcode == `ILCD_OP_CPL_BIT, 2'h2, 2'h2))
		else $error("bit operation decode wrong");

	AST_CARRY_OPS: assert property (
		ilcd_shape(opcode == `ILCD_OP_CLR_C || opcode == `ILCD_OP_SET_C
			|| opcode == `ILCD_OP_CPL_C, 2'h1, 2'h1))
		else $error("carry operation decode wrong");

	// fetch may offer a new byte while busy, so only the accept edge may move it
	AST_HOLD: assert property (@(posedge clk) disable iff (reset)
		busy |=> $stable(dec_out))
		else $error("decode changed while busy");
endmodule : ilcd_decoder

/* tb/ilcd_fetch_model.sv */
module ilcd_fetch_model (
	input wire logic clk,
	input wire logic offer,
	input wire logic [7:0] offer_op,
	output logic opcode_valid,
	output logic [7:0] opcode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_reg = 8'h5a;
	// idle bus flips each cycle so a stale byte never looks fresh
	always @(posedge clk)
		last_reg <= offer ? offer_op : ~last_reg;
	assign opcode_valid = offer;
	assign opcode = offer ? offer_op : last_reg;
endmodule : ilcd_fetch_model

/* tb/tb_top.sv */
`include "ilcd_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, offer, opcode_valid, busy, instr_done;
	logic [7:0] offer_op, opcode;
	ilcd_pkg::ilcd_dec_s dec_out;
	int mismatches = 0, n_checks = 0, seed = 4;
	logic [7:0] ops[$] = '{`ILCD_OP_XRL_DIR_IMM, `ILCD_OP_CLR_A, `ILCD_OP_CPL_A, `ILCD_OP_RL_A,
		`ILCD_OP_RLC_A, `ILCD_OP_RR_A, `ILCD_OP_RRC_A, `ILCD_OP_SWAP_A, `ILCD_OP_A_DIR,
		`ILCD_OP_A_IMM, `ILCD_OP_DIR_A, `ILCD_OP_DIR_DIR, `ILCD_OP_DIR_IMM, `ILCD_OP_IND_DIR,
		`ILCD_OP_IND_IMM, `ILCD_OP_DATA_POINTER_IMM, `ILCD_OP_CODE_DATA_POINTER, `ILCD_OP_CODE_PC,
		`ILCD_OP_XRD_DATA_POINTER, `ILCD_OP_XWR_DATA_POINTER, `ILCD_OP_PUSH, `ILCD_OP_POP, `ILCD_OP_XCH_DIR,
		`ILCD_OP_CLR_C, `ILCD_OP_CLR_BIT, `ILCD_OP_SET_C, `ILCD_OP_SET_BIT, `ILCD_OP_CPL_C,
		`ILCD_OP_CPL_BIT, 8'he6, 8'he8, 8'hf8, 8'h7f, 8'ha8, 8'h88, 8'h86, 8'hf6, 8'he2,
		8'hf3, 8'hc8, 8'hc6, 8'hd6, 8'ha5, 8'he1, 8'hf1};
	ilcd_fetch_model fetch (.clk(clk), .offer(offer), .offer_op(offer_op),
		.opcode_valid(opcode_valid), .opcode(opcode));
	ilcd_decoder uut (.clk(clk), .reset(reset), .opcode_valid(opcode_valid), .opcode(opcode),
		.dec_out(dec_out), .busy(busy), .instr_done(instr_done));
	// packed as valid, length, cycles
	function automatic logic [4:0] expect_of(input logic [7:0] op);
		case (op)
			`ILCD_OP_XRL_DIR_IMM, `ILCD_OP_DIR_DIR, `ILCD_OP_DIR_IMM, `ILCD_OP_DATA_POINTER_IMM:
				return 5'h1f;
			`ILCD_OP_CLR_A, `ILCD_OP_CPL_A, `ILCD_OP_RL_A, `ILCD_OP_RLC_A, `ILCD_OP_RR_A,
			`ILCD_OP_RRC_A, `ILCD_OP_SWAP_A, `ILCD_OP_CLR_C, `ILCD_OP_SET_C, `ILCD_OP_CPL_C,
			8'he8, 8'hf8, 8'hc8: return 5'h15;
			8'he6, 8'hf6, 8'hc6, 8'hd6: return 5'h16;
			`ILCD_OP_CODE_DATA_POINTER, `ILCD_OP_CODE_PC, `ILCD_OP_XRD_DATA_POINTER, `ILCD_OP_XWR_DATA_POINTER,
			8'he2, 8'hf3: return 5'h17;
			8'ha5, 8'he1, 8'hf1: return 5'h00;
			default: return 5'h1a;
		endcase
	endfunction : expect_of
	task automatic check(input string what, input logic [4:0] exp, input logic [4:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : check
	task automatic run(input logic [7:0] op);
		logic [4:0] e;
		int k;
		e = expect_of(op);
		offer = 1'b1;
		offer_op = op;
		@(negedge clk);
		check("decode", e, {dec_out.valid, dec_out.length, dec_out.cycles});
		check("busy", {4'h0, e[1:0] > 2'h1}, {4'h0, busy});
		if (busy === 1'b1)
			offer_op = 8'($random(seed));
		k = 1;
		while (instr_done !== 1'b1 && k < 8)
		begin
			@(negedge clk);
			k++;
		end
		check("cycles", {3'h0, (e[1:0] == 2'h0) ? 2'h1 : e[1:0]}, 5'(k));
		check("held", e, {dec_out.valid, dec_out.length, dec_out.cycles});
	endtask : run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// whole run is a few hundred cycles; this leaves ample slack
	initial
	begin
		#8000;
		mismatches++;
		report_and_stop();
	end
	initial
	begin
		reset = 1'b1;
		offer = 1'b0;
		offer_op = 8'h00;
		repeat (6) @(negedge clk);
		check("reset", 5'h00, {dec_out.valid, dec_out.length, busy, instr_done});
		reset = 1'b0;
		foreach (ops[i]) run(ops[i]);
		$display("sweep done");
		// reset in the middle of a three cycle instruction
		offer_op = `ILCD_OP_DIR_DIR;
		offer = 1'b1;
		@(negedge clk);
		offer = 1'b0;
		reset = 1'b1;
		@(negedge clk);
		check("midreset", 5'h00, {dec_out.valid, dec_out.length, busy, instr_done});
		reset = 1'b0;
		$display("mid reset done");
		repeat (60) run(ops[$unsigned($random(seed)) % ops.size()]);
		$display("random done");
		@(negedge clk);
		offer = 1'b0;
		report_and_stop();
	end
endmodule : tb_top
